//--- bench/rscc_properties.sv
`timescale 1ns/100ps
module rscc_chk (
   // watched ports
   input wire logic       CLK_IN,
   input wire logic       RST_IN,
   input wire logic       SYSTEM_COLD_RESET_IN,
   input wire logic       HOST_BUS_RESET_IN,
   input wire logic       SUSPEND_IN,
   input wire logic [7:0] CTX_OUT,
   input wire logic [7:0] FN_OUT,
   input wire logic       RUN_OUT,
   input wire logic       PIN_OE_OUT
);
   wire c = SYSTEM_COLD_RESET_IN;
   wire h = HOST_BUS_RESET_IN;
   wire s = SUSPEND_IN;
   wire cn = c & ~s;
   wire hn = h & ~s;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   // =========================================================
   // pins reach the state two edges after they are driven
   sequence s_ck; (c && s)[*2]; endsequence
   sequence s_hk; (h && s)[*2]; endsequence
   sequence s_ok; (!c && !h && !s)[*2]; endsequence
   property p_cf; $past(c, 2) |-> !PIN_OE_OUT; endproperty
   a_cf: assert property (p_cf) else $error("cold float");
   property p_cc; $past(cn, 2) |-> CTX_OUT == 8'h00; endproperty
   a_cc: assert property (p_cc) else $error("cold ctx");
   property p_cr; $past(cn, 2) |-> FN_OUT == 8'h00 && !RUN_OUT; endproperty
   a_cr: assert property (p_cr) else $error("cold fn");
   property p_ck; s_ck |-> ##2 $stable(FN_OUT); endproperty
   a_ck: assert property (p_ck) else $error("cold keep");
   property p_hf; $past(h, 2) |-> !PIN_OE_OUT && !RUN_OUT; endproperty
   a_hf: assert property (p_hf) else $error("host float");
   property p_hc; $past(hn, 2) |-> FN_OUT == 8'h00; endproperty
   a_hc: assert property (p_hc) else $error("host fn");
   property p_hk;
      s_hk |-> ##2 ($stable(CTX_OUT) && $stable(FN_OUT));
   endproperty
   a_hk: assert property (p_hk) else $error("host keep");
   property p_ok; s_ok |-> ##2 (RUN_OUT && PIN_OE_OUT); endproperty
   a_ok: assert property (p_ok) else $error("no run");
endmodule
bind rscc_top rscc_chk rscc_chk_inst (.*);

//--- bench/rscc_sys_model.sv
`timescale 1ns/100ps
module rscc_sys_model (
   // boot, bus reset and tie requests
   input  wire logic boot_in,
   input  wire logic bus_in,
   input  wire logic tie_in,
   // reset pins
   output logic      cold_out,
   output logic      host_out
);
   // a tied board loses wake context on every bus reset taken without suspend
   assign cold_out = tie_in ? bus_in : boot_in;
   assign host_out = bus_in;
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
   logic       clk = 1'b0, rst = 1'b1, boot = 1'b0, brst = 1'b0;
   logic       tie = 1'b0, susp = 1'b0, cwr = 1'b0, fwr = 1'b0;
   logic [7:0] cd = 8'h00, fd = 8'h00, ctx, fn;
   logic [1:0] cs = 2'h0, ps = 2'h0, st;
   logic       cold, host, run, oe, c0, c1, p0, p1;
   int         errors = 0, checked = 0, cyc = 0;
   always #5 clk = ~clk;
   rscc_sys_model rscc_sys_model_inst (.boot_in(boot), .bus_in(brst),
      .tie_in(tie), .cold_out(cold), .host_out(host));
   rscc_top rscc_top_inst (.CLK_IN(clk), .RST_IN(rst),
      .SYSTEM_COLD_RESET_IN(cold), .HOST_BUS_RESET_IN(host),
      .SUSPEND_IN(susp), .CTX_WR_IN(cwr), .CTX_DATA_IN(cd), .FN_WR_IN(fwr),
      .FN_DATA_IN(fd), .CORE_SEL_IN(cs), .PROG_SEL_IN(ps), .STATE_OUT(st),
      .CTX_OUT(ctx), .FN_OUT(fn), .RUN_OUT(run),
      .CARD_CORE_SUPPLY_SEL0_OUT(c0), .CARD_CORE_SUPPLY_SEL1_OUT(c1),
      .CARD_PROG_SUPPLY_SEL0_OUT(p0), .CARD_PROG_SUPPLY_SEL1_OUT(p1),
      .PIN_OE_OUT(oe));
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task conclude;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // =========================================================
   // drivers: ap looks four edges on, past the pin sampling delay; wr looks three edges on
   task ap(input logic b, r, u);
      @(posedge clk);
      boot <= b;
      brst <= r;
      susp <= u;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] v);
      @(posedge clk);
      {cwr, fwr, cd, fd, cs, ps} <= {2'h3, v, ~v, v[1:0], v[3:2]};
      @(posedge clk);
      {cwr, fwr} <= 2'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // =========================================================
   // scenarios
   task t_run;
      wr(8'hA5);
      chk("ctx", ctx, 8'hA5);
      chk("fn", fn, 8'h5A);
      chk("sel", {4'h0, c1, c0, p1, p0}, 8'h05);
   endtask
   task t_hs;
      ap(1'b0, 1'b1, 1'b1);
      chk("fn", fn, 8'h5A);
      chk("ctx", ctx, 8'hA5);
      chk("oe", 8'(oe), 8'h00);
      chk("st", 8'(st), 8'h01);
      chk("sel", {4'h0, c1, c0, p1, p0}, 8'h00);
   endtask
   task t_cs;
      ap(1'b1, 1'b0, 1'b1);
      chk("fn", fn, 8'h5A);
      chk("oe", 8'(oe), 8'h00);
      ap(1'b0, 1'b0, 1'b0);
      chk("run", 8'(run), 8'h01);
   endtask
   task t_h;
      wr(8'h3C);
      ap(1'b0, 1'b1, 1'b0);
      chk("fn", fn, 8'h00);
      chk("oe", 8'(oe), 8'h00);
      chk("run", 8'(run), 8'h00);
      ap(1'b0, 1'b0, 1'b0);
      chk("run", 8'(run), 8'h01);
      chk("st", 8'(st), 8'h02);
   endtask
   task t_c;
      wr(8'h96);
      @(posedge clk);
      tie <= 1'b1;
      ap(1'b0, 1'b1, 1'b0);
      chk("ctx", ctx, 8'h00);
      chk("st", 8'(st), 8'h00);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         errors++;
         conclude;
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_run;
      t_hs;
      t_cs;
      t_h;
      t_c;
      conclude;
   end
endmodule

//--- verilog/rscc_pkg.sv
package rscc_pkg;

   // =========================================================
   // widths and reset values
   localparam int            RSCC_CTX_W       = 8;
   localparam int            RSCC_FN_W        = 8;
   localparam logic [7:0]    RSCC_CTX_RST     = 8'h00;
   localparam logic [7:0]    RSCC_FN_RST      = 8'h00;
   localparam logic [1:0]    RSCC_SEL_RST     = 2'h0;

   // =========================================================
   // sequencer states
   typedef enum logic [1:0] {
      RSCC_ST_HELD  = 2'b00,
      RSCC_ST_KEEP  = 2'b01,
      RSCC_ST_RUN   = 2'b10
   } rscc_state_type;

endpackage

//--- verilog/rscc_sync_edge.sv
`timescale 1ns/100ps
module rscc_sync_edge (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // sampled input
   input  wire logic d_in,
   output logic      q_out,
   output logic      rise_out
);
   typedef struct packed {
      logic q;
      logic rise;
   } rscc_se_type;

   rscc_se_type st_reg;
   rscc_se_type st_next;

   // =========================================================
   // rising-edge capture of a bus-clock synchronous input
   always_comb begin
      st_next      = st_reg;
      st_next.q    = d_in;
      st_next.rise = d_in & ~st_reg.q;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q_out    = st_reg.q;
   assign rise_out = st_reg.rise;
endmodule

//--- verilog/rscc_top.sv
// Contract
// [RULE_01] Cold reset floats every output and clears all registers.
// [RULE_02] Cold reset holds the whole device, kept context too, in default.
// [RULE_03] With suspend, cold reset floats outputs but keeps registers.
// [RULE_04] Bus timing comes from the bus clock, inputs sampled on its rise.
// [RULE_05] Host-bus reset floats outputs, clears registers, stops all work.
// [RULE_06] After host-bus reset is released the device runs from default.
// [RULE_07] Suspend with host-bus reset keeps registers while outputs float.
// [RULE_08] The system uses cold reset only at boot, host-bus reset later.
// [RULE_09] Without deep wake-up the system ties cold reset to bus reset.
// [RULE_10] Two outputs select core supply and two select program supply.
`timescale 1ns/100ps
module rscc_top
   import rscc_pkg::*;
(
   // clock and local reset
   input  wire logic                  CLK_IN,
   input  wire logic                  RST_IN,
   // reset and suspend pins
   input  wire logic                  SYSTEM_COLD_RESET_IN,
   input  wire logic                  HOST_BUS_RESET_IN,
   input  wire logic                  SUSPEND_IN,
   // core-side requests
   input  wire logic                  CTX_WR_IN,
   input  wire logic [rscc_pkg::RSCC_CTX_W-1:0] CTX_DATA_IN,
   input  wire logic                  FN_WR_IN,
   input  wire logic [rscc_pkg::RSCC_FN_W-1:0]  FN_DATA_IN,
   input  wire logic [1:0]            CORE_SEL_IN,
   input  wire logic [1:0]            PROG_SEL_IN,
   // status
   output logic [1:0]                 STATE_OUT,
   output logic [rscc_pkg::RSCC_CTX_W-1:0] CTX_OUT,
   output logic [rscc_pkg::RSCC_FN_W-1:0]  FN_OUT,
   output logic                       RUN_OUT,
   // power switch pins
   output logic                       CARD_CORE_SUPPLY_SEL0_OUT,
   output logic                       CARD_CORE_SUPPLY_SEL1_OUT,
   output logic                       CARD_PROG_SUPPLY_SEL0_OUT,
   output logic                       CARD_PROG_SUPPLY_SEL1_OUT,
   output logic                       PIN_OE_OUT
);
   import rscc_pkg::*;

   // =========================================================
   // state
   typedef struct packed {
      rscc_state_type              st;
      logic [RSCC_CTX_W-1:0]       ctx;
      logic [RSCC_FN_W-1:0]        fn;
      logic [1:0]                  core_sel;
      logic [1:0]                  prog_sel;
      logic                        oe;
      logic                        run;
   } rscc_all_type;

   rscc_all_type s_reg;
   rscc_all_type s_next;

   // =========================================================
   // pin sampling
   // limitation: one flop only, so the pins must already be
   // synchronous to the bus clock; a free-running source would
   // need a second stage and add a cycle of latency
   localparam int PIN_N    = 3;
   localparam int PIN_COLD = 0;
   localparam int PIN_HOST = 1;
   localparam int PIN_SUSP = 2;

   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_q;
   logic [PIN_N-1:0] pin_rise;

   logic             cold_q;
   logic             host_q;
   logic             host_rise;
   logic             susp_q;

   assign pin_raw[PIN_COLD] = SYSTEM_COLD_RESET_IN;
   assign pin_raw[PIN_HOST] = HOST_BUS_RESET_IN;
   assign pin_raw[PIN_SUSP] = SUSPEND_IN;

   generate
      for (genvar i = 0; i < PIN_N; i++) begin : g_pin
         rscc_sync_edge u_pin (  // see [RULE_04]
            .clk_in   (CLK_IN),
            .rst_in   (RST_IN),
            .d_in     (pin_raw[i]),
            .q_out    (pin_q[i]),
            .rise_out (pin_rise[i])
         );
      end
   endgenerate

   assign cold_q    = pin_q[PIN_COLD];
   assign host_q    = pin_q[PIN_HOST];
   assign host_rise = pin_rise[PIN_HOST];
   assign susp_q    = pin_q[PIN_SUSP];

   // =========================================================
   // decoding
   function automatic logic in_reset(input logic c, input logic h);
      in_reset = c | h;
   endfunction

   // supply request passes only while running, else switch off
   function automatic logic [1:0] supply_sel(
      input logic       live,
      input logic [1:0] req
   );
      if (live) begin
         supply_sel = req;
      end else begin
         supply_sel = RSCC_SEL_RST;
      end
   endfunction

   logic reset_seen;
   logic shield;
   logic clear_fn;
   logic clear_ctx;

   assign reset_seen = in_reset(cold_q, host_q);
   // suspend shields register contents from either reset
   assign shield     = reset_seen & susp_q;
   assign clear_fn   = reset_seen & ~susp_q;
   // ctx is cleared at the onset of a host reset and held cleared
   // for the whole of a cold reset
   assign clear_ctx  = clear_fn & (cold_q | host_rise);

   // =========================================================
   // sequencer
   always_comb begin
      s_next = s_reg;
      s_next.core_sel = supply_sel(!reset_seen, CORE_SEL_IN);  // see [RULE_10]
      s_next.prog_sel = supply_sel(!reset_seen, PROG_SEL_IN);  // see [RULE_10]
      if (reset_seen) begin
         s_next.oe  = 1'b0;  // see [RULE_01] [RULE_05]
         s_next.run = 1'b0;  // see [RULE_05]
         if (shield) begin
            s_next.st = RSCC_ST_KEEP;  // see [RULE_03] [RULE_07]
         end else begin
            s_next.st = RSCC_ST_HELD;  // see [RULE_02]
         end
         if (clear_fn) begin
            s_next.fn = RSCC_FN_RST;  // see [RULE_01] [RULE_05]
         end
         if (clear_ctx) begin
            s_next.ctx = RSCC_CTX_RST;  // see [RULE_01] [RULE_02]
         end
      end else begin
         s_next.st  = RSCC_ST_RUN;  // see [RULE_06]
         s_next.oe  = 1'b1;
         s_next.run = 1'b1;
         if (CTX_WR_IN) begin
            s_next.ctx = CTX_DATA_IN;
         end
         if (FN_WR_IN) begin
            s_next.fn = FN_DATA_IN;
         end
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         s_reg.st       <= RSCC_ST_HELD;
         s_reg.ctx      <= RSCC_CTX_RST;
         s_reg.fn       <= RSCC_FN_RST;
         s_reg.core_sel <= RSCC_SEL_RST;
         s_reg.prog_sel <= RSCC_SEL_RST;
         s_reg.oe       <= 1'b0;
         s_reg.run      <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // =========================================================
   // outputs, all straight from flops
   assign STATE_OUT                 = s_reg.st;
   assign CTX_OUT                   = s_reg.ctx;
   assign FN_OUT                    = s_reg.fn;
   assign RUN_OUT                   = s_reg.run;
   assign CARD_CORE_SUPPLY_SEL0_OUT = s_reg.core_sel[0];
   assign CARD_CORE_SUPPLY_SEL1_OUT = s_reg.core_sel[1];
   assign CARD_PROG_SUPPLY_SEL0_OUT = s_reg.prog_sel[0];
   assign CARD_PROG_SUPPLY_SEL1_OUT = s_reg.prog_sel[1];
   assign PIN_OE_OUT                = s_reg.oe;
endmodule
